// file: pkg/pbe_pkg.sv
// Types shared by the bridge error block and its delayed-transaction timer.
package pbe_pkg;

   typedef struct packed {
      logic [7:0]  addr;
      logic [15:0] wdata;
      logic        wr;
      logic        rd;
   } pbe_req_s;

   typedef struct packed {
      logic [2:0] tgt_en;
      logic [2:0] tgt_sel;
      logic [5:0] mst_en;
      logic [5:0] mst_sel;
   } pbe_ctrl_s;

   typedef struct packed {
      logic [2:0] flag;
      logic [3:0] master_id;
   } pbe_tgt_stat_s;

   typedef struct packed {
      logic dt_retry_issued;
      logic dt_retried;
      logic tgt_idle;
   } pbe_dt_in_s;

   typedef enum logic [1:0] {
      PBE_DT_IDLE    = 2'b00,
      PBE_DT_WAIT    = 2'b01,
      PBE_DT_EXPIRED = 2'b11
   } pbe_dt_e;

endpackage

// file: pkg/pbe_regs.svh
// Register offsets, field positions, reset values and timing counts of the bridge error block.
`ifndef PBE_REGS_SVH
`define PBE_REGS_SVH

`define PBE_OFF_TGT_CTRL        8'h62
`define PBE_OFF_TGT_STAT        8'h64
`define PBE_OFF_MST_CTRL        8'h66

`define PBE_TGT_EN_LSB          0
`define PBE_TGT_SEL_LSB         8
`define PBE_TGT_FLAG_LSB        0
`define PBE_TGT_ID_LSB          8
`define PBE_MST_EN_LSB          0
`define PBE_MST_SEL_LSB         8

`define PBE_TGT_FIELD_W         3
`define PBE_MST_FIELD_W         6
`define PBE_ID_W                4

`define PBE_RST_TGT_EN          3'h0
`define PBE_RST_TGT_SEL         3'h0
`define PBE_RST_TGT_FLAG        3'h0
`define PBE_RST_MST_EN          6'h00
`define PBE_RST_MST_SEL         6'h00
`define PBE_ID_NONE             4'hf

`define PBE_DLY_TIMEOUT_CLKS    32768

`endif

// file: tb/pbe_far_model.sv
// Behavioural PCI-side agents: target parity errors and delayed-transaction traffic.
module pbe_far_model
   import pbe_pkg::*;
(
   input  logic       clk_sys,
   output logic       tgt_addr_parity_err,
   output logic       tgt_data_parity_err,
   output logic [3:0] active_master_id,
   output pbe_dt_in_s dt_in
);
   timeunit 1ns;
   timeprecision 1ns;
   initial begin
      {tgt_addr_parity_err, tgt_data_parity_err, active_master_id, dt_in} = '0;
   end
   // The owner field turns over after an event, so a late sample shows a wrong id.
   task automatic hit(logic [1:0] k, logic [3:0] id);
      @(posedge clk_sys);
      {tgt_addr_parity_err, tgt_data_parity_err} <= k;
      active_master_id <= id;
      @(posedge clk_sys);
      {tgt_addr_parity_err, tgt_data_parity_err} <= 2'b00;
      active_master_id <= ~id;
      #1;
   endtask
   // The target stays busy well past the time-out, so only the idle spell may fire it.
   task automatic dly(logic cancel);
      @(posedge clk_sys) dt_in.dt_retry_issued <= 1'b1;
      @(posedge clk_sys) dt_in.dt_retry_issued <= 1'b0;
      repeat (4) @(posedge clk_sys);
      dt_in.dt_retried <= cancel;
      @(posedge clk_sys) dt_in.dt_retried <= 1'b0;
      repeat (10) @(posedge clk_sys);
      dt_in.tgt_idle <= 1'b1;
      repeat (4) @(posedge clk_sys);
      dt_in.tgt_idle <= 1'b0;
      #1;
   endtask
endmodule

// file: tb/pbe_top_chk.sv
// Port-level assertions of the bridge error block.
module pbe_top_chk
   import pbe_pkg::*;
(
   input logic        clk_sys,
   input logic        sys_rst,
   input pbe_req_s    reg_req,
   input logic [15:0] reg_rdata,
   input pbe_dt_in_s  dt_in,
   input logic        tgt_addr_parity_err,
   input logic        tgt_data_parity_err,
   input logic        arbiter_grant_timeout_irq,
   input logic        bridge_nmi_gate,
   input logic        global_nmi_gate,
   input logic        dt_discard,
   input logic        bridge_irq,
   input logic        cpu_nmi
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking @(posedge clk_sys); endclocking
   default disable iff (sys_rst);
   logic rd_st, wr_st, rd_tc, wr_tc, clr_all;
   assign rd_st = reg_req.rd && reg_req.addr == 8'h64;
   assign wr_st = reg_req.wr && reg_req.addr == 8'h64;
   assign rd_tc = reg_req.rd && reg_req.addr == 8'h62;
   assign wr_tc = reg_req.wr && reg_req.addr == 8'h62;
   // A parity event in the clearing cycle wins, so it is kept out of the id check.
   assign clr_all = wr_st && reg_req.wdata[2:0] == 3'h7 && !tgt_addr_parity_err && !tgt_data_parity_err;
   ////////////////////////////////////////
   nmi_gate_a: assert property (cpu_nmi |-> $past(bridge_nmi_gate && global_nmi_gate))
      else $error("nmi gate");
   irq_shared_a: assert property (arbiter_grant_timeout_irq |=> bridge_irq)
      else $error("shared irq");
   data_flag_a: assert property (tgt_data_parity_err ##1 !wr_st ##1 rd_st |=> reg_rdata[0])
      else $error("data flag");
   rsv_zero_a: assert property (rd_st |=> reg_rdata[15:12] == 4'h0 && reg_rdata[7:3] == 5'h00)
      else $error("reserved bits");
   disc_pulse_a: assert property (dt_discard |=> !dt_discard)
      else $error("discard width");
   disc_idle_a: assert property (dt_discard |-> $past(dt_in.tgt_idle, 2))
      else $error("discard cause");
   id_clear_a: assert property (clr_all ##1 rd_st && !dt_discard |=> reg_rdata[11:0] == 12'hf00)
      else $error("id after clear");
   ctrl_back_a: assert property (wr_tc ##1 rd_tc |=> reg_rdata == ($past(reg_req.wdata, 2) & 16'h0707))
      else $error("control readback");
   cover property (cpu_nmi);
   cover property (dt_discard);
   cover property (bridge_irq && !arbiter_grant_timeout_irq);
endmodule
////////////////////////////////////////
bind pbe_top pbe_top_chk u_chk (.clk_sys, .sys_rst, .reg_req, .reg_rdata, .dt_in, .tgt_addr_parity_err,
   .tgt_data_parity_err, .arbiter_grant_timeout_irq, .bridge_nmi_gate, .global_nmi_gate, .dt_discard,
   .bridge_irq, .cpu_nmi);

// file: tb/test_pbe_top.sv
// Bench of the bridge error block: drives registers and events, compares with a model.
module test_pbe_top
   import pbe_pkg::*;
   ;
   timeunit 1ns;
   timeprecision 1ns;
   logic        clk_sys = 1'b0;
   logic        sys_rst = 1'b1;
   pbe_req_s    req_q = '0;
   pbe_req_s    reg_req = '0;
   logic [8:0]  lv_q = '0;
   logic [8:0]  lv = '0;
   logic [15:0] reg_rdata, tctl, mctl;
   logic [3:0]  amid, mid;
   logic [2:0]  flag;
   logic        dt_discard, bridge_irq, bridge_nmi, cpu_nmi, a_err, d_err;
   pbe_dt_in_s  dt_in;
   logic [31:0] x = 32'h30;
   int          err_total = 0;
   int          checks = 0;
   int          n_disc = 0;
   ////////////////////////////////////////
   pbe_top #(.DLY_TIMEOUT_CLKS(8)) u_dut (.clk_sys, .sys_rst, .reg_req, .reg_rdata, .dt_in,
      .tgt_addr_parity_err(a_err), .tgt_data_parity_err(d_err), .active_master_id(amid),
      .mst_event_pending(lv[8:3]), .arbiter_grant_timeout_irq(lv[0]), .bridge_nmi_gate(lv[1]),
      .global_nmi_gate(lv[2]), .dt_discard, .bridge_irq, .bridge_nmi, .cpu_nmi);
   pbe_far_model u_far (.clk_sys, .tgt_addr_parity_err(a_err), .tgt_data_parity_err(d_err),
      .active_master_id(amid), .dt_in);
   initial forever #10 clk_sys = ~clk_sys;
   always @(posedge clk_sys) begin
      reg_req <= req_q;
      lv <= lv_q;
      n_disc <= n_disc + int'(dt_discard === 1'b1);
   end
   ////////////////////////////////////////
   function automatic logic [31:0] rnd();
      x ^= x << 13;
      x ^= x >> 17;
      x ^= x << 5;
      return x;
   endfunction
   task automatic cmp(string n, logic [15:0] e, logic [15:0] s);
      checks++;
      if (s !== e) begin
         err_total++;
         $display("unexpected %s: expected %h seen %h", n, e, s);
      end
   endtask
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", checks, err_total);
      if (err_total == 0 && checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic mreset();
      tctl = '0;
      mctl = '0;
      flag = '0;
      mid = 4'hf;
   endtask
   // Requests go through req_q so the bus changes only at a rising edge.
   task automatic acc(logic w, logic [7:0] a, logic [15:0] d);
      req_q = '{a, d, w, !w};
      @(posedge clk_sys) #1;
      req_q = '0;
      if (w && a == 8'h62) tctl = d & 16'h0707;
      if (w && a == 8'h66) mctl = d & 16'h3f3f;
      if (w && a == 8'h64 && d[2:0] != 3'h0) begin
         flag &= ~d[2:0];
         mid = 4'hf;
      end
      if (!w) begin
         @(posedge clk_sys) #1;
         cmp("reg_rdata", a == 8'h62 ? tctl : a == 8'h66 ? mctl : a == 8'h64 ? {4'h0, mid, 5'h00, flag} : 16'h0,
             reg_rdata);
      end
   endtask
   task automatic fire(logic [1:0] k);
      logic [3:0] id;
      id = 4'(rnd() % 5);
      if (flag == 3'h0) mid = id;
      flag |= {1'b0, k};
      u_far.hit(k, id);
   endtask
   task automatic chk_out();
      logic [2:0] pt;
      logic [5:0] pm;
      logic       nmi;
      repeat (4) @(posedge clk_sys);
      #1;
      pt = flag & tctl[2:0];
      pm = lv[8:3] & mctl[5:0];
      nmi = |(pt & tctl[10:8]) || |(pm & mctl[13:8]);
      cmp("irq_lines", 16'({nmi && lv[1] && lv[2], nmi, |(pt & ~tctl[10:8]) || |(pm & ~mctl[13:8]) || lv[0]}),
          16'({cpu_nmi, bridge_nmi, bridge_irq}));
   endtask
   ////////////////////////////////////////
   initial begin
      mreset();
      repeat (16) @(posedge clk_sys);
      sys_rst <= 1'b0;
      #1;
      for (int i = 'h5e; i < 'h6a; i += 2) acc(1'b0, 8'(i), '0);
      for (int i = 0; i < 12; i++) begin
         lv_q = 9'(rnd());
         acc(1'b1, 8'h62, 16'(rnd()) | 16'hf8f8);
         acc(1'b0, 8'h62, '0);
         acc(1'b1, 8'h66, 16'(rnd()) | 16'hc0c0);
         acc(1'b0, 8'h66, '0);
         fire(2'(i % 3 + 1));
         if (i[0]) fire(2'(3 - i % 3));
         acc(1'b0, 8'h64, '0);
         chk_out();
         acc(1'b1, 8'h64, 16'(rnd()) | {13'h0, {3{i[1]}}});
         acc(1'b0, 8'h64, '0);
         chk_out();
      end
      fire(2'b01);
      u_far.dly(1'b1);
      u_far.dly(1'b0);
      flag |= 3'h4;
      acc(1'b0, 8'h64, '0);
      chk_out();
      cmp("discards", 16'h0001, 16'(n_disc));
      @(posedge clk_sys) sys_rst <= 1'b1;
      repeat (2) @(posedge clk_sys);
      sys_rst <= 1'b0;
      #1;
      mreset();
      for (int i = 'h5e; i < 'h6a; i += 2) acc(1'b0, 8'(i), '0);
      wrap_up();
   end
   initial begin
      #100us;
      err_total++;
      wrap_up();
   end
endmodule

// file: verilog/pbe_dly_timer.sv
// Delayed-transaction retry watchdog that reports a time-out once the target side is idle.
`include "pbe_regs.svh"

module pbe_dly_timer
   import pbe_pkg::*;
#(
   parameter int TIMEOUT_CLKS = `PBE_DLY_TIMEOUT_CLKS
) (
   input  wire logic       clk_sys,
   input  wire logic       sys_rst,
   input  wire pbe_dt_in_s dt_in,
   output logic            timeout_pulse
);

   localparam int CW = $clog2(TIMEOUT_CLKS + 1);
   localparam logic [CW-1:0] LAST = CW'(TIMEOUT_CLKS - 1);

   typedef struct packed {
      pbe_dt_e       state;
      logic [CW-1:0] count;
      logic          fire;
   } pbe_dt_state_s;

   pbe_dt_state_s s_reg;
   pbe_dt_state_s s_next;

   ////////////////////////////////////////////////////////////////////////////
   always_comb begin
      s_next      = s_reg;
      s_next.fire = 1'b0;
      unique case (s_reg.state)
         PBE_DT_IDLE: begin
            if (dt_in.dt_retry_issued) begin
               s_next.state = PBE_DT_WAIT;
               s_next.count = '0;
            end
         end
         PBE_DT_WAIT: begin
            if (dt_in.dt_retried) begin
               s_next.state = PBE_DT_IDLE;
            end else if (dt_in.dt_retry_issued) begin
               s_next.count = '0;
            end else if (s_reg.count == LAST) begin
               s_next.state = PBE_DT_EXPIRED;
            end else begin
               s_next.count = s_reg.count + CW'(1);
            end
         end
         PBE_DT_EXPIRED: begin
            // A late retry rescues the request, so no error is flagged for it.
            if (dt_in.dt_retried) begin
               s_next.state = PBE_DT_IDLE;
            end else if (dt_in.tgt_idle) begin
               s_next.state = PBE_DT_IDLE;
               s_next.fire  = 1'b1;
            end
         end
         default: begin
            s_next.state = PBE_DT_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         s_reg <= '{state: PBE_DT_IDLE, count: '0, fire: 1'b0};
      end else begin
         s_reg <= s_next;
      end
   end

   assign timeout_pulse = s_reg.fire;

endmodule

// file: verilog/pbe_top.sv
// Error event latching and interrupt routing of the PCI host bridge.
//
// Functional notes
// - Data parity enable bit 0 gates interrupt.
// - Only system reset clears these registers.
// - Status sets regardless of enable bit.
// - NMI reaches CPU only with both gates.
// - Maskable output shares arbiter time-out input.
// - Record active master in bits 11:8.
// - Identifier all ones when status cleared.
// - Keep first master while several pending.
// - Retry not seen in 2^15 clocks, idle: flag.
// - Discard delayed request when time-out flags.
// - Writing one clears a target status bit.
// - Address parity error always sets bit 1.
// - Data parity error always sets bit 0.
// - Bit 13 routes retry time-out to NMI.
// - Bit 12 routes target abort to NMI.
// - Bit 11 routes master abort to NMI.
// - Bit 10 routes system error to NMI.
// - Target selects 10..8 route to NMI.
// - Target enables 2,1 gate their interrupts.
// - Master selects 9,8 route parity errors.
// - Master enables 5..0 gate their interrupts.
`include "pbe_regs.svh"

module pbe_top
   import pbe_pkg::*;
#(
   parameter int DLY_TIMEOUT_CLKS = `PBE_DLY_TIMEOUT_CLKS
) (
   input  wire logic        clk_sys,
   input  wire logic        sys_rst,
   input  wire pbe_req_s    reg_req,
   output logic [15:0]      reg_rdata,
   input  wire pbe_dt_in_s  dt_in,
   input  wire logic        tgt_addr_parity_err,
   input  wire logic        tgt_data_parity_err,
   input  wire logic [3:0]  active_master_id,
   input  wire logic [5:0]  mst_event_pending,
   input  wire logic        arbiter_grant_timeout_irq,
   input  wire logic        bridge_nmi_gate,
   input  wire logic        global_nmi_gate,
   output logic             dt_discard,
   output logic             bridge_irq,
   output logic             bridge_nmi,
   output logic             cpu_nmi
);

   localparam int NEV = `PBE_TGT_FIELD_W + `PBE_MST_FIELD_W;

   ////////////////////////////////////////////////////////////////////////////
   // Register state.

   typedef struct packed {
      pbe_ctrl_s     ctrl;
      pbe_tgt_stat_s tstat;
      logic [15:0]   rdata;
      logic          discard;
      logic          irq;
      logic          nmi;
      logic          nmi_cpu;
   } pbe_top_state_s;

   pbe_top_state_s s_reg;
   pbe_top_state_s s_next;

   logic           dly_timeout;
   logic [2:0]     tgt_evt;
   logic [NEV-1:0] ev_pend;
   logic [NEV-1:0] ev_en;
   logic [NEV-1:0] ev_sel;
   logic [NEV-1:0] ev_irq;
   logic [NEV-1:0] ev_nmi;

   ////////////////////////////////////////////////////////////////////////////
   // Address decode, used by both the write and the read path.

   function automatic logic hit(input logic [7:0] addr, input logic [7:0] off);
      hit = (addr == off);
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Delayed-transaction retry watchdog.

   pbe_dly_timer #(
      .TIMEOUT_CLKS (DLY_TIMEOUT_CLKS)
   ) u_dly_timer (
      .clk_sys       (clk_sys),
      .sys_rst       (sys_rst),
      .dt_in         (dt_in),
      .timeout_pulse (dly_timeout)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Event vector: target events in bits 2:0, master events in bits 8:3.

   // The parity response setting is deliberately not an input here.
   assign tgt_evt = {dly_timeout, tgt_addr_parity_err, tgt_data_parity_err};

   assign ev_pend = {mst_event_pending, s_reg.tstat.flag};
   assign ev_en   = {s_reg.ctrl.mst_en, s_reg.ctrl.tgt_en};
   assign ev_sel  = {s_reg.ctrl.mst_sel, s_reg.ctrl.tgt_sel};

   generate
      for (genvar i = 0; i < NEV; i++) begin : g_route
         assign ev_irq[i] = ev_pend[i] & ev_en[i] & ~ev_sel[i];
         assign ev_nmi[i] = ev_pend[i] & ev_en[i] & ev_sel[i];
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////
   // Next-state logic.

   always_comb begin
      logic       wr_tctl;
      logic       wr_tsta;
      logic       wr_mctl;
      logic [2:0] clr;
      logic [2:0] kept;
      wr_tctl = reg_req.wr & hit(reg_req.addr, `PBE_OFF_TGT_CTRL);
      wr_tsta = reg_req.wr & hit(reg_req.addr, `PBE_OFF_TGT_STAT);
      wr_mctl = reg_req.wr & hit(reg_req.addr, `PBE_OFF_MST_CTRL);
      clr     = 3'h0;
      kept    = 3'h0;
      s_next  = s_reg;

      // Control writes keep only the defined fields.
      if (wr_tctl) begin
         s_next.ctrl.tgt_en  = reg_req.wdata[`PBE_TGT_EN_LSB +: `PBE_TGT_FIELD_W];
         s_next.ctrl.tgt_sel = reg_req.wdata[`PBE_TGT_SEL_LSB +: `PBE_TGT_FIELD_W];
      end
      if (wr_mctl) begin
         s_next.ctrl.mst_en  = reg_req.wdata[`PBE_MST_EN_LSB +: `PBE_MST_FIELD_W];
         s_next.ctrl.mst_sel = reg_req.wdata[`PBE_MST_SEL_LSB +: `PBE_MST_FIELD_W];
      end

      // Writing a zero leaves a flag alone; a new event beats a clear.
      if (wr_tsta) begin
         clr = reg_req.wdata[`PBE_TGT_FLAG_LSB +: `PBE_TGT_FIELD_W];
      end
      kept = s_reg.tstat.flag & ~clr;
      s_next.tstat.flag = kept | tgt_evt;

      // Only an event that finds no flag left standing may load the master.
      if ((|tgt_evt) && (kept == 3'h0)) begin
         s_next.tstat.master_id = active_master_id;
      end else if (|clr) begin
         s_next.tstat.master_id = `PBE_ID_NONE;
      end else begin
         s_next.tstat.master_id = s_reg.tstat.master_id;
      end

      s_next.discard = dly_timeout;

      s_next.irq     = (|ev_irq) | arbiter_grant_timeout_irq;
      s_next.nmi     = |ev_nmi;
      s_next.nmi_cpu = (|ev_nmi) & bridge_nmi_gate & global_nmi_gate;

      // Registered read answer; unmapped offsets read as zero.
      if (reg_req.rd) begin
         s_next.rdata = 16'h0000;
         if (hit(reg_req.addr, `PBE_OFF_TGT_CTRL)) begin
            s_next.rdata[`PBE_TGT_EN_LSB +: `PBE_TGT_FIELD_W]  = s_reg.ctrl.tgt_en;
            s_next.rdata[`PBE_TGT_SEL_LSB +: `PBE_TGT_FIELD_W] = s_reg.ctrl.tgt_sel;
         end
         if (hit(reg_req.addr, `PBE_OFF_TGT_STAT)) begin
            s_next.rdata[`PBE_TGT_FLAG_LSB +: `PBE_TGT_FIELD_W] = s_reg.tstat.flag;
            s_next.rdata[`PBE_TGT_ID_LSB +: `PBE_ID_W]          = s_reg.tstat.master_id;
         end
         if (hit(reg_req.addr, `PBE_OFF_MST_CTRL)) begin
            s_next.rdata[`PBE_MST_EN_LSB +: `PBE_MST_FIELD_W]  = s_reg.ctrl.mst_en;
            s_next.rdata[`PBE_MST_SEL_LSB +: `PBE_MST_FIELD_W] = s_reg.ctrl.mst_sel;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // State register. Bus reset is not an input, so it cannot disturb the settings.

   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         s_reg.ctrl.tgt_en      <= `PBE_RST_TGT_EN;
         s_reg.ctrl.tgt_sel     <= `PBE_RST_TGT_SEL;
         s_reg.ctrl.mst_en      <= `PBE_RST_MST_EN;
         s_reg.ctrl.mst_sel     <= `PBE_RST_MST_SEL;
         s_reg.tstat.flag       <= `PBE_RST_TGT_FLAG;
         s_reg.tstat.master_id  <= `PBE_ID_NONE;
         s_reg.rdata            <= 16'h0000;
         s_reg.discard          <= 1'b0;
         s_reg.irq              <= 1'b0;
         s_reg.nmi              <= 1'b0;
         s_reg.nmi_cpu          <= 1'b0;
      end else begin
         s_reg <= s_next;
      end
   end

   assign reg_rdata  = s_reg.rdata;
   assign dt_discard = s_reg.discard;
   assign bridge_irq = s_reg.irq;
   assign bridge_nmi = s_reg.nmi;
   assign cpu_nmi    = s_reg.nmi_cpu;

endmodule
